// ===== core/cmsp_defines.svh
// Purpose: constants of the configuration mode-select port
// Assumes: mode codes are written as {bit2,bit1,bit0}
// Notes: widths match the signals that meet them
`ifndef CMSP_DEFINES_SVH
`define CMSP_DEFINES_SVH
// ------------------------------------------------------------------
// mode pin codes
// ------------------------------------------------------------------
`define CMSP_MODE_MSER 3'h0
`define CMSP_MODE_SSER 3'h7
`define CMSP_MODE_MPAR 3'h3
`define CMSP_MODE_SPAR 3'h6
`define CMSP_MODE_TEST 3'h5
// ------------------------------------------------------------------
// register map
// ------------------------------------------------------------------
`define CMSP_REG_CTRL 8'h00
`define CMSP_REG_LEN 8'h04
`define CMSP_REG_STAT 8'h08
`define CMSP_CTRL_RETAIN 0
`define CMSP_CTRL_TOTEM 1
`define CMSP_LEN_RST 32'h00000100
`define CMSP_RESP_OK 2'h0
`define CMSP_RESP_ERR 2'h2
// ------------------------------------------------------------------
// counts and times
// ------------------------------------------------------------------
`define CMSP_CHAIN_MAX 33'h0ffffffe0
`define CMSP_BIT_STEP 33'h000000001
`define CMSP_BYTE_STEP 33'h000000008
`define CMSP_CLEAR_NS 1000
`define CMSP_SYS_NS 100
`endif

// ===== core/cmsp_pkg.sv
// Purpose: types of the configuration mode-select port
// Assumes: nothing beyond the defines header
// Notes: link config crosses as a quasi-static word
package cmsp_pkg;
  typedef enum logic [2:0] {ST_CLEAR, ST_WAIT_INIT, ST_LOAD,
    ST_DONE_WAIT, ST_USER, ST_BAD_MODE} cmsp_state_t;
  typedef enum logic [2:0] {MD_MSER, MD_SSER, MD_MPAR, MD_SPAR,
    MD_TEST, MD_NONE} cmsp_mode_t;
  typedef struct packed {
    logic enable;
    logic serial;
    logic byte_wide;
    logic [31:0] length;
  } cmsp_link_cfg_t;
  typedef struct packed {
    logic done;
    logic overflow;
  } cmsp_link_stat_t;
endpackage

// ===== core/cmsp_sync.sv
// Purpose: two-flop level synchroniser
// Assumes: each bit is an independent level
// Notes: first stage feeds only the second
`timescale 1ns/100ps
module cmsp_sync #(parameter int W = 1)
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta;

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      meta <= '0;
      q_o <= '0;
    end
    else
    begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule

// ===== core/cmsp_link.sv
// Purpose: loading logic on the link clock
// Assumes: length is written before loading starts
// Notes: only the enable is synchronised; status leaves as levels
`timescale 1ns/100ps
`include "cmsp_defines.svh"
module cmsp_link
  import cmsp_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire cmsp_link_cfg_t cfg_i,
  input wire logic [7:0] data_i,
  input wire logic sel_n_i,
  input wire logic rdwr_n_i,
  output logic cascade_o,
  output cmsp_link_stat_t stat_o
);
  logic en;
  logic take_bit;
  logic take_byte;
  logic [32:0] count;

  cmsp_sync #(.W(1)) u_en (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .d_i(cfg_i.enable),
    .q_o(en)
  );

  always_comb
  begin
    take_bit = en & ~cfg_i.byte_wide;
    take_byte = en & cfg_i.byte_wide & ~sel_n_i & ~rdwr_n_i;
  end

  // ------------------------------------------------------------------
  // bit counting
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      count <= '0;
    else if (take_byte)
      count <= count + `CMSP_BYTE_STEP;
    else if (take_bit)
      count <= count + `CMSP_BIT_STEP;
  end

  // sticky, so a wrap in a long test-port stream cannot undo done
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      stat_o <= '0;
    else
    begin
      // gated by en: length reads zero until the first system edge
      // after reset, and a stray link edge there must not finish loading
      if (en && count >= {1'b0, cfg_i.length})
        stat_o.done <= 1'b1;
      if (cfg_i.serial && count > `CMSP_CHAIN_MAX)
        stat_o.overflow <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      cascade_o <= 1'b0;
    else
      cascade_o <= en & cfg_i.serial & data_i[0];
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  property p_par_gate;
    en && cfg_i.byte_wide && sel_n_i |=> $stable(count);
  endproperty
  a_par_gate: assert property (p_par_gate)
    else $error("byte taken while deselected");

  property p_byte_step;
    take_byte |=> count == $past(count) + `CMSP_BYTE_STEP;
  endproperty
  a_byte_step: assert property (p_byte_step)
    else $error("byte did not add eight bits");

  property p_cascade_off;
    !(en && cfg_i.serial) |=> !cascade_o;
  endproperty
  a_cascade_off: assert property (p_cascade_off)
    else $error("cascade active outside serial mode");

  property p_chain_limit;
    cfg_i.serial && count > `CMSP_CHAIN_MAX |=> stat_o.overflow;
  endproperty
  a_chain_limit: assert property (p_chain_limit)
    else $error("chain length over limit not flagged");
endmodule

// ===== core/cmsp_top.sv
// Purpose: configuration entry and mode-select port
// Assumes: ARST_N_I is the program request pin
// Notes: configuration memory itself is outside this block
//
// Contract
// - decode five mode codes, bit or byte loading
// - drive clock in driving modes, else receive
// - cascade output only in serial modes
// - user pull-ups follow disable pin while configuring
// - retain option keeps configuration pins after load
// - without retain, release dual-purpose pins
// - test-port pins keep test function always
// - serial chain limited to 4,294,967,264 bits
// - dedicated and test pins pulled up while configuring
// - sample mode pins on init rising edge
// - program request resets configuration asynchronously
// - completion pin rises at end; low delays start
`timescale 1ns/100ps
`include "cmsp_defines.svh"
module cmsp_top
  import cmsp_pkg::*;
#(
  parameter int CLK_HALF = 2
)
(
  input wire logic CLK_SYS_I,
  input wire logic ARST_N_I,
  input wire logic [7:0] AWADDR_I,
  input wire logic AWVALID_I,
  output logic AWREADY_O,
  input wire logic [31:0] WDATA_I,
  input wire logic [3:0] WSTRB_I,
  input wire logic WVALID_I,
  output logic WREADY_O,
  output logic [1:0] BRESP_O,
  output logic BVALID_O,
  input wire logic BREADY_I,
  input wire logic [7:0] ARADDR_I,
  input wire logic ARVALID_I,
  output logic ARREADY_O,
  output logic [31:0] RDATA_O,
  output logic [1:0] RRESP_O,
  output logic RVALID_O,
  input wire logic RREADY_I,
  input wire logic [2:0] MODE_SELECT_I,
  input wire logic USER_PULLUP_DISABLE_I,
  input wire logic CFG_LOAD_CLK_I,
  output logic CFG_LOAD_CLK_O,
  output logic CFG_LOAD_CLK_OE_O,
  input wire logic TEST_CLK_I,
  input wire logic TEST_DATA_I,
  input wire logic [7:0] CFG_DATA_I,
  input wire logic PARALLEL_SELECT_N_I,
  input wire logic PARALLEL_READ_WRITE_N_I,
  output logic CASCADE_O,
  input wire logic INIT_N_I,
  output logic INIT_N_O,
  output logic INIT_N_OE_O,
  input wire logic DONE_I,
  output logic DONE_O,
  output logic DONE_OE_O,
  output logic USER_PULLUP_EN_O,
  output logic CFG_PIN_PULLUP_EN_O,
  output logic DUAL_PIN_USER_O,
  output logic TEST_PORT_KEEP_O
);
  localparam int CLEAR_CYC =
    (`CMSP_CLEAR_NS + `CMSP_SYS_NS - 1) / `CMSP_SYS_NS;
  localparam logic [7:0] CLEAR_LAST = 8'(CLEAR_CYC - 1);
  localparam logic [7:0] HALF_LAST = 8'(CLK_HALF - 1);

  cmsp_state_t state;
  cmsp_mode_t mode;
  logic [7:0] clear_cnt;
  logic [7:0] div_cnt;
  logic [8:0] pin_s;
  logic [2:0] mode_s;
  logic pud_s;
  logic init_s;
  logic init_d;
  logic init_rise;
  logic done_pin_s;
  logic link_done;
  logic ovf_s;
  logic loading;
  logic master;
  logic ctrl_retain;
  logic ctrl_totem;
  logic [31:0] len_reg;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  cmsp_link_cfg_t cfg_cfg;
  cmsp_link_cfg_t tap_cfg;
  cmsp_link_stat_t cfg_stat;
  cmsp_link_stat_t tap_stat;

  function automatic cmsp_mode_t decode(input logic [2:0] m);
    cmsp_mode_t r;
    r = MD_NONE;
    if (m == `CMSP_MODE_MSER) r = MD_MSER;
    else if (m == `CMSP_MODE_SSER) r = MD_SSER;
    else if (m == `CMSP_MODE_MPAR) r = MD_MPAR;
    else if (m == `CMSP_MODE_SPAR) r = MD_SPAR;
    else if (m == `CMSP_MODE_TEST) r = MD_TEST;
    return r;
  endfunction

  // ------------------------------------------------------------------
  // pin and link status synchronisers
  // ------------------------------------------------------------------
  cmsp_sync #(.W(9)) u_pins (
    .clk_i(CLK_SYS_I),
    .arst_n_i(ARST_N_I),
    .d_i({MODE_SELECT_I, USER_PULLUP_DISABLE_I, INIT_N_I, DONE_I,
      cfg_stat.done, cfg_stat.overflow, tap_stat.done}),
    .q_o(pin_s)
  );

  always_comb
  begin
    mode_s = pin_s[8:6];
    pud_s = pin_s[5];
    init_s = pin_s[4];
    done_pin_s = pin_s[3];
    link_done = pin_s[2] | pin_s[0];
    ovf_s = pin_s[1];
    init_rise = init_s & ~init_d;
    loading = (state == ST_LOAD) || (state == ST_DONE_WAIT);
    master = (mode == MD_MSER) || (mode == MD_MPAR);
  end

  // ------------------------------------------------------------------
  // configuration sequence; program request is the async reset
  // ------------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      state <= ST_CLEAR;
      mode <= MD_NONE;
      init_d <= 1'b0;
      clear_cnt <= 8'h00;
    end
    else
    begin
      init_d <= init_s;
      case (state)
        ST_CLEAR:
        begin
          clear_cnt <= clear_cnt + 8'h01;
          if (clear_cnt == CLEAR_LAST)
            state <= ST_WAIT_INIT;
        end
        ST_WAIT_INIT:
          if (init_rise)
          begin
            mode <= decode(mode_s);
            if (decode(mode_s) == MD_NONE)
              state <= ST_BAD_MODE;
            else
              state <= ST_LOAD;
          end
        ST_LOAD:
          if (link_done)
            state <= ST_DONE_WAIT;
        ST_DONE_WAIT:
          if (done_pin_s)
            state <= ST_USER;
        default:
          state <= state;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // link configuration, held in flops so the crossing is clean
  // ------------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      cfg_cfg <= '0;
      tap_cfg <= '0;
    end
    else
    begin
      cfg_cfg.enable <= loading && mode != MD_TEST;
      cfg_cfg.serial <= mode == MD_MSER || mode == MD_SSER;
      cfg_cfg.byte_wide <= mode == MD_MPAR || mode == MD_SPAR;
      cfg_cfg.length <= len_reg;
      tap_cfg.enable <= loading && mode == MD_TEST;
      tap_cfg.serial <= 1'b0;
      tap_cfg.byte_wide <= 1'b0;
      tap_cfg.length <= len_reg;
    end
  end

  // in driving modes the pin loops back into the same loader
  cmsp_link u_cfg (
    .clk_i(CFG_LOAD_CLK_I),
    .arst_n_i(ARST_N_I),
    .cfg_i(cfg_cfg),
    .data_i(CFG_DATA_I),
    .sel_n_i(PARALLEL_SELECT_N_I),
    .rdwr_n_i(PARALLEL_READ_WRITE_N_I),
    .cascade_o(CASCADE_O),
    .stat_o(cfg_stat)
  );

  cmsp_link u_tap (
    .clk_i(TEST_CLK_I),
    .arst_n_i(ARST_N_I),
    .cfg_i(tap_cfg),
    .data_i({7'h00, TEST_DATA_I}),
    .sel_n_i(1'b1),
    .rdwr_n_i(1'b1),
    .cascade_o(),
    .stat_o(tap_stat)
  );

  // ------------------------------------------------------------------
  // pins: clock, init, done, pull-ups, pin roles
  // ------------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      div_cnt <= 8'h00;
      CFG_LOAD_CLK_O <= 1'b0;
      CFG_LOAD_CLK_OE_O <= 1'b0;
    end
    else
    begin
      CFG_LOAD_CLK_OE_O <= loading & master;
      if (!(loading && master))
      begin
        div_cnt <= 8'h00;
        CFG_LOAD_CLK_O <= 1'b0;
      end
      else if (div_cnt == HALF_LAST)
      begin
        div_cnt <= 8'h00;
        CFG_LOAD_CLK_O <= ~CFG_LOAD_CLK_O;
      end
      else
        div_cnt <= div_cnt + 8'h01;
    end
  end

  // bad mode holds init low so the host can see the fault
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      INIT_N_O <= 1'b0;
      INIT_N_OE_O <= 1'b1;
      DONE_O <= 1'b0;
      DONE_OE_O <= 1'b1;
    end
    else
    begin
      INIT_N_O <= 1'b0;
      INIT_N_OE_O <= state == ST_CLEAR || state == ST_BAD_MODE;
      if (state == ST_DONE_WAIT || state == ST_USER)
      begin
        DONE_O <= ctrl_totem;
        DONE_OE_O <= ctrl_totem;
      end
      else
      begin
        DONE_O <= 1'b0;
        DONE_OE_O <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      USER_PULLUP_EN_O <= 1'b0;
      CFG_PIN_PULLUP_EN_O <= 1'b1;
      DUAL_PIN_USER_O <= 1'b0;
      TEST_PORT_KEEP_O <= 1'b1;
    end
    else
    begin
      USER_PULLUP_EN_O <= state != ST_USER && !pud_s;
      CFG_PIN_PULLUP_EN_O <= state != ST_USER;
      DUAL_PIN_USER_O <= state == ST_USER && !ctrl_retain;
      TEST_PORT_KEEP_O <= 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // AXI4-Lite slave
  // ------------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      AWREADY_O <= 1'b1;
      WREADY_O <= 1'b1;
      BVALID_O <= 1'b0;
      BRESP_O <= `CMSP_RESP_OK;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      ctrl_retain <= 1'b0;
      ctrl_totem <= 1'b0;
      len_reg <= `CMSP_LEN_RST;
    end
    else
    begin
      if (AWVALID_I && AWREADY_O)
      begin
        aw_addr <= AWADDR_I;
        AWREADY_O <= 1'b0;
      end
      if (WVALID_I && WREADY_O)
      begin
        w_data <= WDATA_I;
        w_strb <= WSTRB_I;
        WREADY_O <= 1'b0;
      end
      if (!AWREADY_O && !WREADY_O && !BVALID_O)
      begin
        BVALID_O <= 1'b1;
        BRESP_O <= `CMSP_RESP_OK;
        if (aw_addr == `CMSP_REG_CTRL)
        begin
          if (w_strb[0])
          begin
            ctrl_retain <= w_data[`CMSP_CTRL_RETAIN];
            ctrl_totem <= w_data[`CMSP_CTRL_TOTEM];
          end
        end
        else if (aw_addr == `CMSP_REG_LEN)
        begin
          for (int b = 0; b < 4; b++)
            if (w_strb[b])
              len_reg[8*b +: 8] <= w_data[8*b +: 8];
        end
        else if (aw_addr != `CMSP_REG_STAT)
          BRESP_O <= `CMSP_RESP_ERR;
      end
      if (BVALID_O && BREADY_I)
      begin
        BVALID_O <= 1'b0;
        AWREADY_O <= 1'b1;
        WREADY_O <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      ARREADY_O <= 1'b1;
      RVALID_O <= 1'b0;
      RDATA_O <= 32'h00000000;
      RRESP_O <= `CMSP_RESP_OK;
    end
    else if (ARVALID_I && ARREADY_O)
    begin
      ARREADY_O <= 1'b0;
      RVALID_O <= 1'b1;
      RRESP_O <= `CMSP_RESP_OK;
      RDATA_O <= 32'h00000000;
      if (ARADDR_I == `CMSP_REG_CTRL)
        RDATA_O <= {30'h00000000, ctrl_totem, ctrl_retain};
      else if (ARADDR_I == `CMSP_REG_LEN)
        RDATA_O <= len_reg;
      else if (ARADDR_I == `CMSP_REG_STAT)
        RDATA_O <= {21'h000000, ovf_s, done_pin_s, link_done,
          1'b0, 3'(mode), 1'b0, 3'(state)};
      else
        RRESP_O <= `CMSP_RESP_ERR;
    end
    else if (RVALID_O && RREADY_I)
    begin
      RVALID_O <= 1'b0;
      ARREADY_O <= 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!ARST_N_I);

  property p_mode_sample;
    state == ST_WAIT_INIT && init_rise |=> mode == decode($past(mode_s));
  endproperty
  a_mode_sample: assert property (p_mode_sample)
    else $error("mode not sampled at init rise");

  property p_bad_mode;
    state == ST_WAIT_INIT && init_rise && decode(mode_s) == MD_NONE
      |=> state == ST_BAD_MODE ##1 INIT_N_OE_O;
  endproperty
  a_bad_mode: assert property (p_bad_mode)
    else $error("unknown mode code accepted");

  sequence s_master_load;
    loading && master ##1 loading && master;
  endsequence
  property p_clk_drive;
    s_master_load |-> CFG_LOAD_CLK_OE_O;
  endproperty
  a_clk_drive: assert property (p_clk_drive)
    else $error("clock not driven in driving mode");

  property p_clk_recv;
    !master |=> !CFG_LOAD_CLK_OE_O;
  endproperty
  a_clk_recv: assert property (p_clk_recv)
    else $error("clock driven in receiving mode");

  property p_pullup;
    state != ST_USER |=> USER_PULLUP_EN_O == !$past(pud_s);
  endproperty
  a_pullup: assert property (p_pullup)
    else $error("user pull-up does not follow disable pin");

  property p_cfg_pullup;
    state != ST_USER |=> CFG_PIN_PULLUP_EN_O && TEST_PORT_KEEP_O;
  endproperty
  a_cfg_pullup: assert property (p_cfg_pullup)
    else $error("dedicated pull-up off while configuring");

  property p_retain;
    ctrl_retain |=> !DUAL_PIN_USER_O && TEST_PORT_KEEP_O;
  endproperty
  a_retain: assert property (p_retain)
    else $error("pins released while retained");

  property p_release;
    state == ST_USER && !ctrl_retain |=> DUAL_PIN_USER_O;
  endproperty
  a_release: assert property (p_release)
    else $error("dual-purpose pins not released");

  sequence s_done_held;
    state == ST_DONE_WAIT && !done_pin_s;
  endsequence
  property p_done_hold;
    s_done_held |=> state == ST_DONE_WAIT
      ##0 DONE_O == ctrl_totem ##0 DONE_OE_O == ctrl_totem;
  endproperty
  a_done_hold: assert property (p_done_hold)
    else $error("start-up not delayed by low done");
endmodule

// ===== dv/cmsp_partner.sv
// Purpose: configuration source beside the mode-select port
// Assumes: bench owns run, stall and seed
// Notes: idle clocks sit at the pull-up level, idle data inverted
`timescale 1ns/100ps
module cmsp_partner
(
  input wire logic run_i,
  input wire logic stall_i,
  input wire logic [7:0] seed_i,
  input wire logic clk_drv_i,
  input wire logic clk_oe_i,
  output logic load_clk_o,
  output logic test_clk_o,
  output logic [7:0] data_o,
  output logic sel_n_o,
  output logic rdwr_n_o
);
  logic own = 1'b0;
  logic [7:0] d = 8'h01;
  // --------------------
  // clocks and data
  // --------------------
  // odd start offset keeps this clock unrelated to the system clock
  initial
  begin
    #3.1;
    forever #7.5 own = ~own;
  end
  // driven clock loops back; else we supply it only within frames
  assign load_clk_o = clk_oe_i ? clk_drv_i : (run_i ? own : 1'b1);
  assign test_clk_o = run_i ? own : 1'b1;
  // data moves on falling edges so it is settled at the rising one
  always @(negedge load_clk_o or negedge test_clk_o)
    d <= run_i ? {d[6:0], d[7] ^ d[5] ^ d[4] ^ d[3]} : (seed_i | 8'h01);
  assign data_o = run_i ? d : ~d;
  // bytes are written only with select and write low
  assign sel_n_o = !run_i || stall_i;
  assign rdwr_n_o = !run_i;
endmodule

// ===== dv/testbench.sv
// Purpose: self-checking bench of the mode-select port
// Assumes: register reads are checked from a queue of notes
// Notes: loading length kept at 24 bits to keep the run short
`timescale 1ns/100ps
`include "cmsp_defines.svh"
module testbench;
  import cmsp_pkg::*;
  typedef struct {
    logic [31:0] exp;
    logic [31:0] mask;
    logic [1:0] resp;
  } cmsp_note_t;
  logic CLK_SYS_I = 1'b0;
  logic ARST_N_I = 1'b0;
  logic AWVALID_I = 1'b0, WVALID_I = 1'b0, BREADY_I = 1'b0;
  logic ARVALID_I = 1'b0, RREADY_I = 1'b0;
  logic [7:0] AWADDR_I = 8'h00, ARADDR_I = 8'h00;
  logic [31:0] WDATA_I = 32'h0;
  logic [2:0] MODE_SELECT_I = 3'h0;
  logic USER_PULLUP_DISABLE_I = 1'b1;
  logic AWREADY_O, WREADY_O, BVALID_O, ARREADY_O, RVALID_O, CASCADE_O;
  logic [1:0] BRESP_O, RRESP_O;
  logic [31:0] RDATA_O;
  logic CFG_LOAD_CLK_I, CFG_LOAD_CLK_O, CFG_LOAD_CLK_OE_O, TEST_CLK_I;
  logic [7:0] CFG_DATA_I;
  logic PARALLEL_SELECT_N_I, PARALLEL_READ_WRITE_N_I;
  logic INIT_N_I, INIT_N_O, INIT_N_OE_O, DONE_I, DONE_O, DONE_OE_O;
  logic USER_PULLUP_EN_O, CFG_PIN_PULLUP_EN_O, DUAL_PIN_USER_O;
  logic TEST_PORT_KEEP_O;
  logic run = 1'b0, stall = 1'b0, init_hold = 1'b1, done_hold = 1'b1;
  logic casc_seen = 1'b0;
  logic [31:0] lfsr = 32'h00013a90, rdat;
  logic [1:0] wq[$];
  cmsp_note_t rq[$];
  cmsp_note_t note;
  int failures = 0, samples_checked = 0;

  always #50 CLK_SYS_I = ~CLK_SYS_I;
  // open-drain pins resolved with board pull-ups
  assign INIT_N_I = (INIT_N_OE_O ? INIT_N_O : 1'b1) & !init_hold;
  assign DONE_I = DONE_OE_O ? DONE_O : !done_hold;
  always @(posedge CASCADE_O) casc_seen = 1'b1;

  cmsp_top #(.CLK_HALF(2)) cmsp_top_inst (.CLK_SYS_I, .ARST_N_I,
    .AWADDR_I, .AWVALID_I, .AWREADY_O, .WDATA_I, .WSTRB_I(4'hf),
    .WVALID_I, .WREADY_O, .BRESP_O, .BVALID_O, .BREADY_I, .ARADDR_I,
    .ARVALID_I, .ARREADY_O, .RDATA_O, .RRESP_O, .RVALID_O, .RREADY_I,
    .MODE_SELECT_I, .USER_PULLUP_DISABLE_I, .CFG_LOAD_CLK_I,
    .CFG_LOAD_CLK_O, .CFG_LOAD_CLK_OE_O, .TEST_CLK_I,
    .TEST_DATA_I(CFG_DATA_I[0]), .CFG_DATA_I, .PARALLEL_SELECT_N_I,
    .PARALLEL_READ_WRITE_N_I, .CASCADE_O, .INIT_N_I, .INIT_N_O,
    .INIT_N_OE_O, .DONE_I, .DONE_O, .DONE_OE_O, .USER_PULLUP_EN_O,
    .CFG_PIN_PULLUP_EN_O, .DUAL_PIN_USER_O, .TEST_PORT_KEEP_O);
  cmsp_partner cmsp_partner_inst (.run_i(run), .stall_i(stall),
    .seed_i(lfsr[7:0]), .clk_drv_i(CFG_LOAD_CLK_O),
    .clk_oe_i(CFG_LOAD_CLK_OE_O), .load_clk_o(CFG_LOAD_CLK_I),
    .test_clk_o(TEST_CLK_I), .data_o(CFG_DATA_I),
    .sel_n_o(PARALLEL_SELECT_N_I), .rdwr_n_o(PARALLEL_READ_WRITE_N_I));

  // --------------------
  // tasks
  // --------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] r);
    wq.push_back(r);
    AWADDR_I <= a;
    WDATA_I <= d;
    AWVALID_I <= 1'b1;
    WVALID_I <= 1'b1;
    BREADY_I <= 1'b1;
    do
    begin
      @(posedge CLK_SYS_I);
      if (AWREADY_O)
        AWVALID_I <= 1'b0;
      if (WREADY_O)
        WVALID_I <= 1'b0;
    end
    while (!BVALID_O);
    BREADY_I <= 1'b0;
    // one edge between transfers so ready is never set twice at once
    @(posedge CLK_SYS_I);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
    input logic [31:0] m, input logic [1:0] r);
    rq.push_back('{e, m, r});
    ARADDR_I <= a;
    ARVALID_I <= 1'b1;
    RREADY_I <= 1'b1;
    do
    begin
      @(posedge CLK_SYS_I);
      if (ARREADY_O)
        ARVALID_I <= 1'b0;
    end
    while (!RVALID_O);
    rdat = RDATA_O;
    RREADY_I <= 1'b0;
    @(posedge CLK_SYS_I);
  endtask

  // polls the state field; mask zero means no note is compared
  task automatic wait_st(input logic [2:0] s);
    int k;
    k = 0;
    do
    begin
      rd(`CMSP_REG_STAT, 32'h0, 32'h0, `CMSP_RESP_OK);
      k++;
    end
    while (rdat[2:0] !== s && k < 300);
    check(32'(rdat[2:0]), 32'(s));
  endtask

  task automatic do_reset;
    ARST_N_I <= 1'b0;
    run <= 1'b1;
    repeat (8) @(posedge CLK_SYS_I);
    check(32'(INIT_N_OE_O), 32'h1);
    check(32'(INIT_N_O), 32'h0);
    ARST_N_I <= 1'b1;
    run <= 1'b0;
    @(posedge CLK_SYS_I);
  endtask

  // --------------------
  // checking and stimulus
  // --------------------
  always @(posedge CLK_SYS_I)
  begin
    if (BVALID_O && BREADY_I)
      check(32'(BRESP_O), 32'(wq.pop_front()));
    if (RVALID_O && RREADY_I)
    begin
      note = rq.pop_front();
      if (note.mask != 32'h0)
      begin
        check(RDATA_O & note.mask, note.exp);
        check(32'(RRESP_O), 32'(note.resp));
      end
    end
  end

  initial
  begin
    #3000000;
    failures++;
    test_done();
  end

  initial
  begin : main
    logic [2:0] code [5];
    logic pud, ret, tot;
    code = '{`CMSP_MODE_MSER, `CMSP_MODE_SSER, `CMSP_MODE_MPAR,
      `CMSP_MODE_SPAR, `CMSP_MODE_TEST};
    for (int i = 0; i < 5; i++)
    begin
      lfsr = lfsr_next(lfsr);
      pud = lfsr[3];
      ret = i[1];
      tot = i[0];
      init_hold <= 1'b1;
      done_hold <= !tot;
      MODE_SELECT_I <= code[i];
      USER_PULLUP_DISABLE_I <= pud;
      do_reset();
      casc_seen = 1'b0;
      rd(`CMSP_REG_CTRL, 32'h0, 32'hffffffff, `CMSP_RESP_OK);
      rd(`CMSP_REG_LEN, `CMSP_LEN_RST, 32'hffffffff, 2'h0);
      wr(`CMSP_REG_LEN, 32'h18, `CMSP_RESP_OK);
      wr(`CMSP_REG_CTRL, {30'h0, tot, ret}, `CMSP_RESP_OK);
      rd(`CMSP_REG_LEN, 32'h18, 32'hffffffff, `CMSP_RESP_OK);
      init_hold <= 1'b0;
      wait_st(ST_LOAD);
      // pins move after sampling; the decoded mode must not follow
      MODE_SELECT_I <= ~code[i];
      repeat (2) @(posedge CLK_SYS_I);
      check(32'(CFG_LOAD_CLK_OE_O), 32'(i == 0 || i == 2));
      check(32'(USER_PULLUP_EN_O), 32'(!pud));
      check(32'(CFG_PIN_PULLUP_EN_O), 32'h1);
      check(32'(DUAL_PIN_USER_O), 32'h0);
      if (i == 2 || i == 3)
      begin
        stall <= 1'b1;
        run <= 1'b1;
        repeat (40) @(posedge CLK_SYS_I);
        rd(`CMSP_REG_STAT, 32'h2, 32'h107, `CMSP_RESP_OK);
        stall <= 1'b0;
      end
      run <= 1'b1;
      if (!tot)
      begin
        wait_st(ST_DONE_WAIT);
        check(32'(DONE_OE_O), 32'h0);
        done_hold <= 1'b0;
      end
      wait_st(ST_USER);
      run <= 1'b0;
      rd(`CMSP_REG_STAT, {25'h0, 3'(i), 4'h4}, 32'h77, 2'h0);
      check(32'(DUAL_PIN_USER_O), 32'(!ret));
      check(32'(TEST_PORT_KEEP_O), 32'h1);
      check(32'(USER_PULLUP_EN_O), 32'h0);
      check(32'(CFG_PIN_PULLUP_EN_O), 32'h0);
      check(32'(casc_seen), 32'(i < 2));
      if (tot)
        check(32'({DONE_OE_O, DONE_O}), 32'h3);
      $display("test of mode %0d ended", i);
    end
    MODE_SELECT_I <= 3'h1;
    init_hold <= 1'b1;
    do_reset();
    init_hold <= 1'b0;
    wait_st(ST_BAD_MODE);
    repeat (4) @(posedge CLK_SYS_I);
    check(32'(INIT_N_OE_O), 32'h1);
    $display("test of unknown mode ended");
    wr(8'h0c, 32'h3, `CMSP_RESP_ERR);
    rd(8'h0c, 32'h0, 32'hffffffff, `CMSP_RESP_ERR);
    wr(`CMSP_REG_STAT, 32'h3, `CMSP_RESP_OK);
    rd(`CMSP_REG_CTRL, 32'h0, 32'hffffffff, `CMSP_RESP_OK);
    $display("test of bus refusals ended");
    test_done();
  end
endmodule
